// file: fpsc_pkg.sv
package fpsc_pkg;
	// ************************************************************
	// register byte addresses (printed offsets are not all /4)
	// ************************************************************
	localparam logic [7:0] FPSC_IDX_FAN_ONE_DRIVE = 8'h56; // drive reg one
	localparam logic [7:0] FPSC_IDX_FAN_TWO_DRIVE = 8'h57; // drive reg two
	localparam logic [7:0] FPSC_IDX_FAN_CTRL = 8'h58; // shared control
	localparam int FPSC_ADDR_W = 12; // byte address width
	localparam logic [11:0] FPSC_ADDR_FAN_ONE_DRIVE = 12'h158; // 4 * 0x56
	localparam logic [11:0] FPSC_ADDR_FAN_TWO_DRIVE = 12'h15c; // 4 * 0x57
	localparam logic [11:0] FPSC_ADDR_FAN_CTRL = 12'h160; // 4 * 0x58

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] FPSC_RST_DRIVE = 8'h00; // both drive regs
	localparam logic [7:0] FPSC_RST_CTRL = 8'h50; // both divisors = 2
	localparam logic [3:0] FPSC_RST_DIV = 4'h2; // decoded divide by 2

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int FPSC_DRV_FORCE_BIT = 0; // pin forced high
	localparam int FPSC_DRV_DUTY_LSB = 1; // duty field low bit
	localparam int FPSC_DRV_CLKSEL_BIT = 7; // clock select
	localparam int FPSC_CTL_SRC_LSB = 0; // source bits 1:0 per channel
	localparam int FPSC_CTL_MUL_LSB = 2; // doubler bits 3:2 per channel
	localparam int FPSC_CTL_DIV_LSB = 4; // divisor fields 5:4, 7:6
	localparam int FPSC_DUTY_W = 6; // duty width, 64 slots

	// ************************************************************
	// axi responses
	// ************************************************************
	localparam logic [1:0] FPSC_RESP_OKAY = 2'h0; // accepted
	localparam logic [1:0] FPSC_RESP_SLVERR = 2'h2; // unmapped

	// ************************************************************
	// slot rate: clocks per slot for select/source combination
	// ************************************************************
	localparam int FPSC_SLOT_W = 16; // slot prescaler width
	localparam logic [15:0] FPSC_SLOT_S0_C0 = 16'h0100; // sel0 src0
	localparam logic [15:0] FPSC_SLOT_S0_C1 = 16'h0080; // sel0 src1
	localparam logic [15:0] FPSC_SLOT_S1_C0 = 16'h0040; // sel1 src0
	localparam logic [15:0] FPSC_SLOT_S1_C1 = 16'h0020; // sel1 src1
endpackage : fpsc_pkg

// file: fpsc_channel.sv
`timescale 1ns/1ps
// one pwm channel: prescaled slot counter and 64-slot waveform
module fpsc_channel
	import fpsc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] drive,
	input wire logic clk_src,
	input wire logic clk_mul,
	output logic fan_out
);
	// ************************************************************
	// state
	// ************************************************************
	logic [FPSC_SLOT_W-1:0] pre_q, pre_d; // slot prescaler
	logic [FPSC_DUTY_W-1:0] slot_q, slot_d; // slot index in period
	logic out_q, out_d; // registered pin level
	logic [FPSC_SLOT_W-1:0] period; // clocks per slot
	logic [FPSC_DUTY_W-1:0] duty; // high slot count

	// next-state logic
	always_comb begin
		duty = drive[FPSC_DRV_DUTY_LSB +: FPSC_DUTY_W];
		// rate from clock select and source together
		case ({drive[FPSC_DRV_CLKSEL_BIT], clk_src})
			2'b00: period = FPSC_SLOT_S0_C0;
			2'b01: period = FPSC_SLOT_S0_C1;
			2'b10: period = FPSC_SLOT_S1_C0;
			default: period = FPSC_SLOT_S1_C1;
		endcase
		// halving slot length doubles the frequency
		if (clk_mul) begin
			period = period >> 1;
		end
		pre_d = pre_q + 16'h0001;
		slot_d = slot_q;
		if (pre_q >= period - 16'h0001) begin
			// slot ends; a shortened period never strands the counter
			pre_d = '0;
			slot_d = slot_q + 6'h01;
		end
		if (drive[FPSC_DRV_FORCE_BIT]) begin
			out_d = 1'b1;
		end else begin
			// high while slot below duty: 0 low, 32 half, 63 of 64
			out_d = (slot_q < duty);
		end
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= '0;
			slot_q <= '0;
			out_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			slot_q <= slot_d;
			out_q <= out_d;
		end
	end

	assign fan_out = out_q;
endmodule // fpsc_channel

// file: fpsc_top.sv
`timescale 1ns/1ps
// What this block does
// - drive bit 0 forces fan pin high
// - duty field counts high slots of 64
// - duty code 100000 gives half duty
// - select, source and doubler set frequency
// - control bit 2 doubles channel one
// - control bit 3 doubles channel two
// - bits 5:4 channel one divisor, default 2
// - bits 7:6 channel two divisor, 00=1 01=2
// - divisor decoded to tach_divisor_one/two for the tachometer count outside
module fpsc_top
	import fpsc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic fan_output_one,
	output logic fan_output_two,
	output logic [3:0] tach_divisor_one,
	output logic [3:0] tach_divisor_two
);
	import fpsc_pkg::*;

	// ************************************************************
	// register and bus state
	// ************************************************************
	logic [7:0] drv_one_q, drv_one_d; // channel one drive
	logic [7:0] drv_two_q, drv_two_d; // channel two drive
	logic [7:0] ctrl_q, ctrl_d; // shared control
	logic [11:0] awaddr_q, awaddr_d; // held write address
	logic aw_have_q, aw_have_d; // write address taken
	logic [7:0] wdata_q, wdata_d; // held write byte
	logic wstrb_q, wstrb_d; // lane 0 strobe held
	logic w_have_q, w_have_d; // write data taken
	logic bvalid_q, bvalid_d; // write response pending
	logic [1:0] bresp_q, bresp_d; // write response code
	logic rvalid_q, rvalid_d; // read response pending
	logic [1:0] rresp_q, rresp_d; // read response code
	logic [31:0] rdata_q, rdata_d; // read data
	logic [7:0] rd_byte; // decoded read value
	logic rd_hit; // read address mapped

	// handshake readies are combinational: one write, one read at a time
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;

	// read decode
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			FPSC_ADDR_FAN_ONE_DRIVE: rd_byte = drv_one_q;
			FPSC_ADDR_FAN_TWO_DRIVE: rd_byte = drv_two_q;
			FPSC_ADDR_FAN_CTRL: rd_byte = ctrl_q;
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// bus next-state
	// ************************************************************
	always_comb begin
		drv_one_d = drv_one_q;
		drv_two_d = drv_two_q;
		ctrl_d = ctrl_q;
		awaddr_d = awaddr_q;
		aw_have_d = aw_have_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		w_have_d = w_have_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		// capture address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_have_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_d = s_axi_wdata[7:0];
			wstrb_d = s_axi_wstrb[0];
			w_have_d = 1'b1;
		end
		// both halves held: commit one cycle later
		if (aw_have_q && w_have_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = FPSC_RESP_OKAY;
			// only lane 0 carries data; upper lanes ignored
			case (awaddr_q)
				FPSC_ADDR_FAN_ONE_DRIVE: begin
					if (wstrb_q) begin
						drv_one_d = wdata_q;
					end
				end
				FPSC_ADDR_FAN_TWO_DRIVE: begin
					if (wstrb_q) begin
						drv_two_d = wdata_q;
					end
				end
				FPSC_ADDR_FAN_CTRL: begin
					if (wstrb_q) begin
						ctrl_d = wdata_q;
					end
				end
				default: bresp_d = FPSC_RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// read answered the cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = {24'h000000, rd_byte};
			rresp_d = rd_hit ? FPSC_RESP_OKAY : FPSC_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// bus registers; defaults load on standby power-on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drv_one_q <= FPSC_RST_DRIVE;
			drv_two_q <= FPSC_RST_DRIVE;
			ctrl_q <= FPSC_RST_CTRL;
			awaddr_q <= '0;
			aw_have_q <= 1'b0;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= FPSC_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= FPSC_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			drv_one_q <= drv_one_d;
			drv_two_q <= drv_two_d;
			ctrl_q <= ctrl_d;
			awaddr_q <= awaddr_d;
			aw_have_q <= aw_have_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			w_have_q <= w_have_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// ************************************************************
	// tachometer divisors, decoded for the counter block outside
	// ************************************************************
	// the divisor scales the latched per-pulse tick count
	function automatic logic [3:0] fpsc_div(input logic [1:0] code);
		fpsc_div = 4'h1 << code; // 00=1 01=2 10=4 11=8
	endfunction

	logic [3:0] div_one_q; // registered divisor one
	logic [3:0] div_two_q; // registered divisor two
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_one_q <= FPSC_RST_DIV;
			div_two_q <= FPSC_RST_DIV;
		end else begin
			div_one_q <= fpsc_div(ctrl_q[FPSC_CTL_DIV_LSB +: 2]);
			div_two_q <= fpsc_div(ctrl_q[FPSC_CTL_DIV_LSB+2 +: 2]);
		end
	end
	assign tach_divisor_one = div_one_q;
	assign tach_divisor_two = div_two_q;

	// ************************************************************
	// the two pwm channels
	// ************************************************************
	logic [1:0] fan_pins; // channel outputs
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			fpsc_channel u_ch (
				.aclk(aclk),
				.aresetn(aresetn),
				.drive(ch == 0 ? drv_one_q : drv_two_q),
				.clk_src(ctrl_q[FPSC_CTL_SRC_LSB + ch]),
				.clk_mul(ctrl_q[FPSC_CTL_MUL_LSB + ch]),
				.fan_out(fan_pins[ch])
			);
		end
	endgenerate
	assign fan_output_one = fan_pins[0];
	assign fan_output_two = fan_pins[1];
endmodule // fpsc_top

// file: fpsc_props.sv
`timescale 1ns/1ps
// ****
// handshake and divisor checks at the top ports
// ****
module fpsc_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] tach_divisor_one,
	input wire logic [3:0] tach_divisor_two
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
	a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready while bvalid");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_div_reset: assert property ($rose(aresetn) |->
		tach_divisor_one == 4'h2 && tach_divisor_two == 4'h2)
		else $error("divisor default");
	a_div_code: assert property ($onehot(tach_divisor_one)
		&& $onehot(tach_divisor_two)) else $error("divisor code");
	// a divisor may only move while a write answer is out or the cycle after
	a_div_cause: assert property ($changed({tach_divisor_one,
		tach_divisor_two}) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("divisor moved");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_div: cover property ($changed(tach_divisor_two));
endmodule // fpsc_props
bind fpsc_top fpsc_props fpsc_props_i (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.tach_divisor_one, .tach_divisor_two);

// file: fpsc_fan_model.sv
`timescale 1ns/1ps
// ****
// fan drive stage: times high run and period, rise to rise
// ****
module fpsc_fan_model (
	input wire logic aclk,
	input wire logic [1:0] fan_in,
	output logic [15:0] hi [2],
	output logic [15:0] per [2]
);
	logic [1:0] prev_q = 2'h0; // last pin levels
	logic [15:0] cnt_q [2]; // cycles since last rise
	logic [15:0] hc_q [2]; // high cycles since last rise
	// a rise closes one period; counts before the first rise are junk
	always @(posedge aclk) begin
		prev_q <= fan_in;
		for (int i = 0; i < 2; i++) begin
			if (fan_in[i] && !prev_q[i]) begin
				per[i] <= cnt_q[i];
				hi[i] <= hc_q[i];
				cnt_q[i] <= 16'h1;
				hc_q[i] <= 16'h1;
			end else begin
				cnt_q[i] <= cnt_q[i] + 16'h1;
				hc_q[i] <= hc_q[i] + 16'(fan_in[i]);
			end
		end
	end
endmodule // fpsc_fan_model

// file: fpsc_top_test.sv
`timescale 1ns/1ps
module fpsc_top_test;
	import fpsc_pkg::*;
	// ****
	// stimulus and observed signals
	// ****
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1; // lane 0 holds each register
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic fan_output_one, fan_output_two;
	logic [3:0] tach_divisor_one, tach_divisor_two;
	logic [15:0] hi [2], per [2]; // pin timing seen by the fan stage
	int error_cnt = 0, comparisons = 0;
	always #25 aclk = ~aclk; // 20 mhz
	fpsc_top fpsc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fan_output_one,
		.fan_output_two, .tach_divisor_one, .tach_divisor_two);
	fpsc_fan_model fpsc_fan_model_i (.aclk,
		.fan_in({fan_output_two, fan_output_one}), .hi, .per);
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	// bready lags so the held answer is exercised
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r);
		int n = 0;
		bit done;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			done = s_axi_bvalid && s_axi_bready;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			s_axi_bready <= n > 2 && !done;
		end while (!done);
		chk(s_axi_bresp, r);
	endtask
	// rready lags one cycle behind rvalid
	task automatic rd(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] r);
		int n = 0;
		bit done;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			done = s_axi_rvalid && s_axi_rready;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			s_axi_rready <= n > 1 && !done;
		end while (!done);
		chk(s_axi_rdata, {24'h0, d});
		chk(s_axi_rresp, r);
	endtask
	// count cycles where a pin leaves the expected level
	task automatic steady(input bit ch, input logic lv);
		int bad = 0;
		repeat (1200) begin
			@(posedge aclk);
			bad += ((ch ? fan_output_two : fan_output_one) !== lv);
		end
		chk(bad, 0);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd(FPSC_ADDR_FAN_TWO_DRIVE, 8'h00, FPSC_RESP_OKAY);
		rd(FPSC_ADDR_FAN_CTRL, 8'h50, FPSC_RESP_OKAY);
		chk(tach_divisor_one, 4'h2);
		chk(tach_divisor_two, 4'h2);
		wr(12'h164, 8'hff, FPSC_RESP_SLVERR);
		rd(12'h164, 8'h00, FPSC_RESP_SLVERR);
		// a write with lane 0 masked is answered but changes nothing
		s_axi_wstrb <= 4'h0;
		wr(FPSC_ADDR_FAN_ONE_DRIVE, 8'hff, FPSC_RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(FPSC_ADDR_FAN_ONE_DRIVE, 8'h00, FPSC_RESP_OKAY);
	endtask
	// every divisor code on both channels
	task automatic t_div;
		for (int c = 0; c < 4; c++) begin
			wr(FPSC_ADDR_FAN_CTRL, {2'(c), 2'(c), 4'h0}, FPSC_RESP_OKAY);
			repeat (2) @(posedge aclk);
			chk(tach_divisor_one, 4'h1 << c);
			chk(tach_divisor_two, 4'h1 << c);
			rd(FPSC_ADDR_FAN_CTRL, {2'(c), 2'(c), 4'h0}, FPSC_RESP_OKAY);
		end
	endtask
	// force bit wins over a zero duty field
	task automatic t_force;
		wr(FPSC_ADDR_FAN_ONE_DRIVE, 8'h01, FPSC_RESP_OKAY);
		steady(1'b0, 1'b1);
	endtask
	task automatic t_duty;
		wr(FPSC_ADDR_FAN_CTRL, 8'h51, FPSC_RESP_OKAY);
		wr(FPSC_ADDR_FAN_ONE_DRIVE, 8'hc0, FPSC_RESP_OKAY);
		repeat (7000) @(posedge aclk);
		chk(hi[0], 32 * FPSC_SLOT_S1_C1);
		chk(per[0], 64 * FPSC_SLOT_S1_C1);
		wr(FPSC_ADDR_FAN_CTRL, 8'h55, FPSC_RESP_OKAY);
		repeat (3500) @(posedge aclk);
		chk(per[0], 32 * FPSC_SLOT_S1_C1);
		wr(FPSC_ADDR_FAN_CTRL, 8'h5a, FPSC_RESP_OKAY);
		wr(FPSC_ADDR_FAN_TWO_DRIVE, 8'hfe, FPSC_RESP_OKAY);
		repeat (3500) @(posedge aclk);
		chk(hi[1], 63 * FPSC_SLOT_S1_C1 / 2);
		chk(per[1], 32 * FPSC_SLOT_S1_C1);
	endtask
	// zero duty: pin two drops low at once; checked after a one period wait
	task automatic t_zero;
		wr(FPSC_ADDR_FAN_TWO_DRIVE, 8'h80, FPSC_RESP_OKAY);
		repeat (1100) @(posedge aclk);
		steady(1'b1, 1'b0);
	endtask
	// the remaining select and source pairs, with and without doubling
	task automatic t_rate;
		wr(FPSC_ADDR_FAN_CTRL, 8'h54, FPSC_RESP_OKAY);
		wr(FPSC_ADDR_FAN_ONE_DRIVE, 8'h40, FPSC_RESP_OKAY);
		wr(FPSC_ADDR_FAN_TWO_DRIVE, 8'hc0, FPSC_RESP_OKAY);
		repeat (17000) @(posedge aclk);
		chk(per[0], 32 * FPSC_SLOT_S0_C0);
		chk(hi[0], 16 * FPSC_SLOT_S0_C0);
		chk(per[1], 64 * FPSC_SLOT_S1_C0);
		wr(FPSC_ADDR_FAN_CTRL, 8'h55, FPSC_RESP_OKAY);
		repeat (9000) @(posedge aclk);
		chk(per[0], 32 * FPSC_SLOT_S0_C1);
	endtask
	task automatic conclude;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_div();
		t_force();
		t_duty();
		t_zero();
		t_rate();
		conclude();
	end
	// the run needs about 44k cycles; cut a hang at 70k
	initial begin
		#3500000;
		error_cnt++;
		conclude();
	end
endmodule // fpsc_top_test
